// [shared/cpi_pkg.sv]
// constants and types for the channel program interpreter
// assumes a 16-bit memory word and eight devices per channel
package cpi_pkg;
    localparam int unsigned CPI_NDEV = 8;
    localparam int unsigned CPI_DEV_W = 3;
    localparam int unsigned CPI_WORD_W = 16;
    // device entry layout, four words per device
    localparam logic [1:0] CPI_ENT_PTR = 2'h0;
    localparam logic [1:0] CPI_ENT_VAR = 2'h1;
    localparam logic [1:0] CPI_ENT_STAT = 2'h3;
    localparam int unsigned CPI_ENT_SHIFT = 2;
    // status bits of entry word 3
    localparam int unsigned CPI_ST_RUN = 0;
    localparam int unsigned CPI_ST_PEND = 1;
    // opcode field: bits 15:4 of the instruction word
    localparam logic [11:0] CPI_OP_RJMP = 12'h000;
    localparam logic [11:0] CPI_OP_INTR = 12'h013;
    localparam logic [11:0] CPI_OP_WAIT = 12'h020;
    localparam logic [11:0] CPI_OP_READ = 12'h033;
    localparam logic [11:0] CPI_OP_WRITE = 12'h043;
    localparam logic [11:0] CPI_OP_DSJ = 12'h052;
    localparam logic [11:0] CPI_OP_IDENT = 12'h060;
    localparam logic [11:0] CPI_OP_RDCTL = 12'h072;
    localparam logic [11:0] CPI_OP_WRCTL = 12'h082;
    localparam logic [11:0] CPI_OP_CLEAR = 12'h092;
    localparam logic [11:0] CPI_OP_RMW = 12'h0a0;
    localparam logic [11:0] CPI_OP_RDREG = 12'h0b0;
    localparam logic [11:0] CPI_OP_WRREG = 12'h0c0;
    localparam logic [11:0] CPI_OP_CMD = 12'h0d0;
    localparam logic [11:0] CPI_OP_DMA = 12'h0ec;
    localparam logic [11:0] CPI_OP_WRI = 12'h0f2;
    localparam logic [11:0] CPI_OP_CRCI = 12'h102;
    localparam logic [11:0] CPI_OP_CRCC = 12'h112;
    // interrupt variants: second word high byte
    localparam logic [7:0] CPI_INT_HALT = 8'h18;
    localparam logic [7:0] CPI_INT_RUN = 8'h10;
    // secondary address prefixes
    localparam logic [3:0] CPI_SEC_DATA = 4'h6;
    localparam logic [3:0] CPI_SEC_CTRL = 4'h7;
    // data chain word: low nibble; the top byte is compared with zero
    localparam logic [3:0] CPI_CHAIN_TAG = 4'h0;
    // abort cause written into the variable area
    localparam logic [15:0] CPI_ABORT_BADOP = 16'h0001;
    localparam logic [15:0] CPI_ABORT_WORD = 16'h0000;
    typedef enum logic [1:0] {
        CPI_GRP_FUNC, CPI_GRP_INTER, CPI_GRP_NONINT, CPI_GRP_BAD
    } cpi_grp_t;
endpackage

// [verilog/cpi_interp.sv]
// channel program interpreter: arbitration, entry status, fetch/decode
// assumes single-cycle synchronous memory and bus ports, one clock
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1 - serve the next requesting device numbered above the last one served
// RQ2 - run only while the service request line is asserted; keep cpu state; here the line only gates leaving idle, a service runs on after it drops
// RQ3 - each of eight devices owns a four-word entry set up by software
// RQ4 - on start request write word 3 bits 0,1 to 1,0 then run program
// RQ5 - halt request writes bits 0,1 to 0,1 and makes the device ask service
// RQ6 - servicing a pending halt ends the program and clears both bits
// RQ7 - halt takes effect after the current instruction, by the next wait
// RQ8 - self halt or abort clears both status bits at once
// RQ9 - software treats program as live until both status bits read zero
// RQ10 - entry word 0 holds next instruction address, updated by interpreter
// RQ11 - entry word 1 points at the variable area used for abort details
// RQ12 - every opcode decodes into exactly one of three groups
// RQ13 - non-interactive instructions cause no bus activity to the device
// RQ14 - interactive instructions send a secondary right after addressing
// RQ15 - secondaries are 0110SSSS for data and 0111SSSS for control
// RQ16 - shared control secondaries are told apart by talk versus listen
// RQ17 - interrupt 018X halts after raising, 010X keeps running
// RQ18 - chained read and write use word 00X0, X giving blocks left
// RQ19 - software acts only by altering programs or start and halt
// RQ20 - undefined opcode aborts, records cause, and clears status bits
module cpi_interp
    import cpi_pkg::*;
#(
    parameter int unsigned ADDR_W = 16
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // channel side
    input wire logic channel_service_request_line,
    input wire logic [cpi_pkg::CPI_NDEV-1:0] dev_req,
    input wire logic [cpi_pkg::CPI_NDEV-1:0] start_req,
    input wire logic [cpi_pkg::CPI_NDEV-1:0] halt_req,
    input wire logic [ADDR_W-1:0] entry_table_base,
    // memory port, read data valid one cycle after mem_rd
    output logic mem_rd,
    output logic mem_wr,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [cpi_pkg::CPI_WORD_W-1:0] mem_wdata,
    input wire logic [cpi_pkg::CPI_WORD_W-1:0] mem_rdata,
    // instrument bus command port
    output logic bus_send,
    output logic bus_talk,
    output logic [7:0] bus_secondary,
    output logic [cpi_pkg::CPI_DEV_W-1:0] bus_dev,
    output logic chan_irq,
    output logic [cpi_pkg::CPI_DEV_W-1:0] chan_irq_dev,
    output logic [cpi_pkg::CPI_NDEV-1:0] halt_pending,
    output logic busy
);
    import cpi_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_RDST, ST_STAT, ST_RDPTR, ST_PTR, ST_FETCH,
        ST_OPND, ST_EXEC, ST_RDVAR, ST_VAR, ST_STORE
    } cpi_state_t;

    typedef struct packed {
        cpi_state_t st;
        logic [CPI_DEV_W-1:0] last;
        logic [CPI_DEV_W-1:0] cur;
        logic [CPI_NDEV-1:0] pend;
        logic [CPI_WORD_W-1:0] stat;
        logic [ADDR_W-1:0] pc;
        logic [CPI_WORD_W-1:0] op;
        logic [CPI_WORD_W-1:0] opnd;
        logic abort;
        logic mem_rd;
        logic mem_wr;
        logic [ADDR_W-1:0] mem_addr;
        logic [CPI_WORD_W-1:0] mem_wdata;
        logic bus_send;
        logic bus_talk;
        logic [7:0] bus_secondary;
        logic irq;
        logic busy;
        logic [CPI_NDEV-1:0] hreq;
    } cpi_reg_t;

    cpi_reg_t r_q, r_d;
    logic [CPI_NDEV-1:0] want;
    logic [CPI_DEV_W-1:0] pick;
    logic found;
    logic [ADDR_W-1:0] ent;
    cpi_grp_t grp;
    logic [CPI_NDEV-1:0] hrise;

    ////////////////////////////////////////////////////////////////////
    // round-robin pick, starting just above the device served last
    always_comb begin
        want = dev_req | start_req | halt_req | r_q.pend;
        pick = r_q.last;
        found = 1'b0;
        for (int i = CPI_NDEV; i >= 1; i--) begin
            if (want[3'(r_q.last + 3'(i))]) begin
                pick = 3'(r_q.last + 3'(i)); // RQ1
                found = 1'b1;
            end
        end
    end

    // entry base of current device: four words each
    assign ent = entry_table_base + (ADDR_W'(r_q.cur) << CPI_ENT_SHIFT); // RQ3

    // halt requests are held levels; only a new one may set a pending flag,
    // otherwise a request still held at the end would re-arm the halt
    assign hrise = halt_req & ~r_q.hreq;

    ////////////////////////////////////////////////////////////////////
    // opcode grouping; unknown codes are their own group for aborting
    always_comb begin
        case (r_q.op[15:4])
            CPI_OP_RJMP, CPI_OP_INTR, CPI_OP_WAIT:
                grp = CPI_GRP_NONINT; // RQ12
            CPI_OP_READ, CPI_OP_WRITE, CPI_OP_DSJ, CPI_OP_IDENT,
            CPI_OP_RDCTL, CPI_OP_WRCTL, CPI_OP_CLEAR:
                grp = CPI_GRP_INTER;
            CPI_OP_RMW, CPI_OP_RDREG, CPI_OP_WRREG, CPI_OP_CMD,
            CPI_OP_DMA, CPI_OP_WRI, CPI_OP_CRCI, CPI_OP_CRCC:
                grp = CPI_GRP_FUNC;
            default:
                grp = CPI_GRP_BAD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // interpreter sequence; strobes are one cycle by default
    always_comb begin
        r_d = r_q;
        r_d.mem_rd = 1'b0;
        r_d.mem_wr = 1'b0;
        r_d.bus_send = 1'b0;
        r_d.irq = 1'b0;
        // a fresh halt request latches a pending flag and beats a clear
        r_d.hreq = halt_req;
        r_d.pend = r_q.pend | hrise;
        case (r_q.st)
            ST_IDLE: begin
                if (channel_service_request_line && found) begin // RQ2
                    r_d.cur = pick;
                    r_d.last = pick;
                    r_d.abort = 1'b0;
                    r_d.st = ST_RDST;
                end
            end
            ST_RDST: begin
                r_d.mem_rd = 1'b1;
                r_d.mem_addr = ent | ADDR_W'(CPI_ENT_STAT);
                r_d.st = ST_STAT;
            end
            ST_STAT: begin
                if (!r_q.mem_rd) begin
                    r_d.stat = mem_rdata;
                    r_d.mem_wr = 1'b1;
                    r_d.mem_addr = r_q.mem_addr;
                    r_d.st = ST_RDPTR;
                    r_d.mem_wdata = mem_rdata;
                    if (halt_req[r_q.cur]) begin
                        // first report status change
                        r_d.mem_wdata[CPI_ST_RUN] = 1'b0; // RQ5
                        r_d.mem_wdata[CPI_ST_PEND] = 1'b1;
                    end else if (r_q.pend[r_q.cur]) begin
                        r_d.mem_wdata[CPI_ST_RUN] = 1'b0; // RQ6
                        r_d.mem_wdata[CPI_ST_PEND] = 1'b0;
                        r_d.pend[r_q.cur] = hrise[r_q.cur];
                        r_d.st = ST_IDLE;
                    end else if (start_req[r_q.cur]) begin
                        r_d.mem_wdata[CPI_ST_RUN] = 1'b1; // RQ4
                        r_d.mem_wdata[CPI_ST_PEND] = 1'b0;
                    end else if (!mem_rdata[CPI_ST_RUN]) begin
                        // halted program: nothing to run
                        r_d.mem_wr = 1'b0;
                        r_d.st = ST_IDLE;
                    end
                    if (halt_req[r_q.cur] && !mem_rdata[CPI_ST_RUN]) begin
                        r_d.st = ST_IDLE;
                    end
                end
            end
            ST_RDPTR: begin
                r_d.mem_rd = 1'b1;
                r_d.mem_addr = ent | ADDR_W'(CPI_ENT_PTR);
                r_d.st = ST_PTR;
            end
            ST_PTR: begin
                if (!r_q.mem_rd) begin
                    r_d.pc = ADDR_W'(mem_rdata); // RQ10
                    r_d.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                r_d.mem_rd = 1'b1;
                r_d.mem_addr = r_q.pc;
                r_d.st = ST_OPND;
            end
            ST_OPND: begin
                if (!r_q.mem_rd) begin
                    if (r_q.mem_addr == r_q.pc) begin
                        r_d.op = mem_rdata;
                        r_d.mem_rd = 1'b1;
                        r_d.mem_addr = r_q.pc + ADDR_W'(1);
                    end else begin
                        r_d.opnd = mem_rdata;
                        r_d.pc = r_q.pc + ADDR_W'(2);
                        r_d.st = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                r_d.st = ST_FETCH;
                case (grp)
                    CPI_GRP_NONINT: begin
                        // no bus traffic toward the device
                        if (r_q.op[15:4] == CPI_OP_RJMP) begin // RQ13
                            r_d.pc = r_q.pc + ADDR_W'(r_q.opnd);
                        end else if (r_q.op[15:4] == CPI_OP_INTR) begin
                            r_d.irq = 1'b1;
                            if (r_q.opnd[15:8] == CPI_INT_HALT) begin
                                r_d.st = ST_STORE; // RQ17
                            end
                        end else begin
                            // wait: suspend, or stop if halt pending
                            r_d.st = ST_STORE; // RQ7
                        end
                    end
                    CPI_GRP_INTER: begin
                        // secondary follows addressing in same command
                        r_d.bus_send = 1'b1; // RQ14
                        r_d.bus_secondary = {
                            (r_q.op[15:4] == CPI_OP_READ ||
                             r_q.op[15:4] == CPI_OP_WRITE) ?
                            CPI_SEC_DATA : CPI_SEC_CTRL,
                            r_q.opnd[3:0]}; // RQ15
                        // read-type ops talk, write-type ops listen
                        r_d.bus_talk = (r_q.op[15:4] == CPI_OP_READ) ||
                            (r_q.op[15:4] == CPI_OP_RDCTL) ||
                            (r_q.op[15:4] == CPI_OP_DSJ) ||
                            (r_q.op[15:4] == CPI_OP_IDENT); // RQ16
                        // chained blocks: 00X0 with X nonzero continues
                        if ((r_q.op[15:4] == CPI_OP_READ ||
                             r_q.op[15:4] == CPI_OP_WRITE) &&
                            r_q.opnd[15:8] == 8'h00 &&
                            r_q.opnd[3:0] == CPI_CHAIN_TAG &&
                            r_q.opnd[7:4] != 4'h0) begin
                            // count the block off in memory, else it loops
                            r_d.mem_wr = 1'b1;
                            r_d.mem_addr = r_q.pc - ADDR_W'(1);
                            r_d.mem_wdata = {r_q.opnd[15:8],
                                r_q.opnd[7:4] - 4'h1, r_q.opnd[3:0]};
                            r_d.pc = r_q.pc - ADDR_W'(2); // RQ18
                        end
                    end
                    CPI_GRP_FUNC: begin
                        r_d.bus_send = 1'b1;
                        r_d.bus_talk = 1'b0;
                        r_d.bus_secondary = r_q.opnd[7:0];
                    end
                    default: begin
                        r_d.abort = 1'b1; // RQ20
                        r_d.st = ST_RDVAR;
                    end
                endcase
                if (r_q.pend[r_q.cur] && grp != CPI_GRP_BAD) begin
                    r_d.st = ST_STORE; // RQ7
                end
            end
            ST_RDVAR: begin
                r_d.mem_rd = 1'b1;
                r_d.mem_addr = ent | ADDR_W'(CPI_ENT_VAR);
                r_d.st = ST_VAR;
            end
            ST_VAR: begin
                if (!r_q.mem_rd) begin
                    // abort cause into the variable area
                    r_d.mem_wr = 1'b1; // RQ11
                    r_d.mem_addr = ADDR_W'(mem_rdata) +
                        ADDR_W'(CPI_ABORT_WORD);
                    r_d.mem_wdata = CPI_ABORT_BADOP;
                    r_d.st = ST_STORE;
                end
            end
            ST_STORE: begin
                // save pointer, then status word if the program ends here
                if (r_q.mem_addr != (ent | ADDR_W'(CPI_ENT_PTR)) ||
                    !r_q.mem_wr) begin
                    r_d.mem_wr = 1'b1;
                    r_d.mem_addr = ent | ADDR_W'(CPI_ENT_PTR);
                    r_d.mem_wdata = CPI_WORD_W'(r_q.pc); // RQ10
                end else begin
                    r_d.st = ST_IDLE;
                    if (r_q.abort || r_q.pend[r_q.cur] ||
                        r_q.op[15:4] == CPI_OP_INTR) begin
                        r_d.mem_wr = 1'b1;
                        r_d.mem_addr = ent | ADDR_W'(CPI_ENT_STAT);
                        r_d.mem_wdata = r_q.stat;
                        r_d.mem_wdata[CPI_ST_RUN] = 1'b0; // RQ8
                        r_d.mem_wdata[CPI_ST_PEND] = 1'b0;
                        r_d.pend[r_q.cur] = hrise[r_q.cur];
                    end
                end
            end
            default: r_d.st = ST_IDLE;
        endcase
        r_d.busy = (r_d.st != ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////
    // state register; enable low freezes everything
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_q <= '0;
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    assign mem_rd = r_q.mem_rd;
    assign mem_wr = r_q.mem_wr;
    assign mem_addr = r_q.mem_addr;
    assign mem_wdata = r_q.mem_wdata;
    assign bus_send = r_q.bus_send;
    assign bus_talk = r_q.bus_talk;
    assign bus_secondary = r_q.bus_secondary;
    assign bus_dev = r_q.cur;
    assign chan_irq = r_q.irq;
    assign chan_irq_dev = r_q.cur;
    assign halt_pending = r_q.pend;
    assign busy = r_q.busy;
endmodule
`default_nettype wire

// [bench/cpi_interp_assertions.sv]
// port checker for the channel program interpreter
// assumes the entry table base is aligned to four words
`timescale 1ns/1ps
`default_nettype none
module cpi_chk
    import cpi_pkg::*;
#(
    parameter int unsigned ADDR_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // watched ports
    input wire logic channel_service_request_line,
    input wire logic [cpi_pkg::CPI_NDEV-1:0] halt_req,
    input wire logic mem_rd,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic bus_send,
    input wire logic [7:0] bus_secondary,
    input wire logic chan_irq,
    input wire logic [cpi_pkg::CPI_NDEV-1:0] halt_pending,
    input wire logic busy
);
    import cpi_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    // a service never starts on its own
    AST_TAKE_CSRQ: assert property (
        $rose(busy) |-> $past(channel_service_request_line))
        else $error("service began without request line");
    AST_IDLE_HOLD: assert property (
        !busy && !channel_service_request_line |=> !busy)
        else $error("left idle with request line low");
    // status word is looked at before anything else
    AST_STAT_FIRST: assert property (
        $rose(busy) |-> ##[0:1] (mem_rd && mem_addr[1:0] == CPI_ENT_STAT))
        else $error("first access is not the status word");
    AST_SEND_BUSY: assert property (
        bus_send |-> busy)
        else $error("bus traffic outside a service");
    AST_SEC_FMT: assert property (
        bus_send |-> bus_secondary[7:5] == 3'h3)
        else $error("secondary prefix wrong");
    AST_SEND_PULSE: assert property (
        bus_send |=> !bus_send)
        else $error("secondary sent twice in a row");
    AST_HALT_LATCH: assert property (
        $rose(|halt_req) |-> ##[1:3] (|halt_pending))
        else $error("halt request not latched");
    AST_IRQ_BUSY: assert property (
        chan_irq |-> busy || $past(busy))
        else $error("interrupt outside a service");
endmodule
bind cpi_interp cpi_chk #(.ADDR_W(ADDR_W)) i_chk (.clk, .resetn,
    .channel_service_request_line, .halt_req, .mem_rd, .mem_addr,
    .bus_send, .bus_secondary, .chan_irq, .halt_pending, .busy);
`default_nettype wire

// [bench/cpi_mem_model.sv]
// memory and bus-device model at the interpreter's far side
// assumes 256 words; read data stand only the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module cpi_mem_model (
    // clock
    input wire logic clk,
    // memory port
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output var logic [15:0] mem_rdata,
    // device bus and interrupts
    input wire logic bus_send,
    input wire logic bus_talk,
    input wire logic [7:0] bus_secondary,
    input wire logic [2:0] bus_dev,
    input wire logic chan_irq,
    input wire logic [2:0] chan_irq_dev,
    input wire logic [7:0] halt_pending
);
    // four-word entries and variable areas live here
    logic [15:0] mem [0:255];
    logic [11:0] bus_log[$];
    logic [2:0] irq_log[$];
    logic [15:0] rd_first;
    logic [7:0] hp_seen;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
        mem_rdata = 16'h0000;
        rd_first = 16'hffff;
        hp_seen = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    // stale read data flip so a late sample never matches by luck
    always @(posedge clk) begin
        mem_rdata <= mem_rd ? mem[mem_addr[7:0]] : ~mem_rdata;
        if (mem_wr) begin
            mem[mem_addr[7:0]] <= mem_wdata;
        end
        if (mem_rd && rd_first == 16'hffff) begin
            rd_first <= mem_addr;
        end
        // device takes the secondary as its directive
        if (bus_send) begin
            bus_log.push_back({bus_talk, bus_dev, bus_secondary});
        end
        if (chan_irq) begin
            irq_log.push_back(chan_irq_dev);
        end
        hp_seen <= hp_seen | halt_pending;
    end
endmodule
`default_nettype wire

// [bench/cpi_interp_tb_top.sv]
// testbench for the channel program interpreter
// assumes the memory model answers every read one cycle later
`timescale 1ns/1ps
`default_nettype none
module cpi_interp_tb_top;
    import cpi_pkg::*;
    localparam logic [15:0] BASE = 16'h0040;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic csrq = 1'b0;
    logic [7:0] dev_req = 8'h00;
    logic [7:0] start_req = 8'h00;
    logic [7:0] halt_req = 8'h00;
    logic mem_rd, mem_wr, bus_send, bus_talk, chan_irq, busy;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    logic [7:0] bus_secondary, halt_pending;
    logic [2:0] bus_dev, chan_irq_dev;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    cpi_interp i_dut (.clk, .resetn, .clk_en(1'b1),
        .channel_service_request_line(csrq), .dev_req, .start_req,
        .halt_req, .entry_table_base(BASE), .mem_rd, .mem_wr, .mem_addr,
        .mem_wdata, .mem_rdata, .bus_send, .bus_talk, .bus_secondary,
        .bus_dev, .chan_irq, .chan_irq_dev, .halt_pending, .busy);
    cpi_mem_model i_mem (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
        .mem_rdata, .bus_send, .bus_talk, .bus_secondary, .bus_dev,
        .chan_irq, .chan_irq_dev, .halt_pending);
    ////////////////////////////////////////////////////////////
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] st(input int d);
        return {14'h0, i_mem.mem[BASE + 4 * d + 3][1:0]};
    endfunction
    task automatic entry(input int d, input logic [15:0] pc);
        i_mem.mem[BASE + 4 * d] = pc;
        i_mem.mem[BASE + 4 * d + 1] = 16'h00c0;
        i_mem.mem[BASE + 4 * d + 3] = 16'h0000;
    endtask
    task automatic ins(input int a, input logic [15:0] op, logic [15:0] x);
        i_mem.mem[a] = op;
        i_mem.mem[a + 1] = x;
    endtask
    // hold start and halt until the service is over, then drop them
    task automatic serve(input logic [7:0] w, st_m, hl_m);
        int n;
        i_mem.bus_log.delete();
        i_mem.irq_log.delete();
        @(posedge clk);
        dev_req <= w;
        start_req <= st_m;
        halt_req <= hl_m;
        csrq <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busy !== 1'b1 && n < 50);
        cmp_word({15'h0, busy}, 16'h0001);
        @(posedge clk);
        csrq <= 1'b0;
        dev_req <= 8'h00;
        n = 0;
        while (busy !== 1'b0 && n < 500) begin
            @(negedge clk);
            n++;
        end
        cmp_word({15'h0, busy}, 16'h0000);
        @(posedge clk);
        start_req <= 8'h00;
        halt_req <= 8'h00;
        // the closing status write lands on this edge; look after it
        @(negedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        // interactive data, control by listen and talk, run interrupt
        entry(2, 16'h0080);
        ins(16'h80, 16'h0330, 16'h0005);
        ins(16'h82, 16'h0820, 16'h0003);
        ins(16'h84, 16'h0720, 16'h0003);
        ins(16'h86, 16'h0130, 16'h1000);
        ins(16'h88, 16'h0200, 16'h0000);
        serve(8'h04, 8'h04, 8'h00);
        cmp_word(16'(i_mem.bus_log.size()), 16'h0003);
        cmp_word({4'h0, i_mem.bus_log[0]}, 16'h0a65);
        cmp_word({4'h0, i_mem.bus_log[1]}, 16'h0273);
        cmp_word({4'h0, i_mem.bus_log[2]}, 16'h0a73);
        cmp_word({13'h0, i_mem.irq_log[0]}, 16'h0002);
        cmp_word(st(2), 16'h0001);
        cmp_word(i_mem.mem[BASE + 8], 16'h008a);
        $display("test program run done");
        // interrupt that halts the program
        entry(3, 16'h0090);
        ins(16'h90, 16'h0130, 16'h1800);
        serve(8'h08, 8'h08, 8'h00);
        cmp_word(16'(i_mem.irq_log.size()), 16'h0001);
        cmp_word(16'(i_mem.bus_log.size()), 16'h0000);
        cmp_word(st(3), 16'h0000);
        $display("test interrupt halt done");
        // three devices ask after device three was served
        entry(1, 16'h00a0);
        entry(5, 16'h00a0);
        entry(7, 16'h00a0);
        ins(16'ha0, 16'h0200, 16'h0000);
        ins(16'ha2, 16'h0200, 16'h0000);
        i_mem.rd_first = 16'hffff;
        serve(8'ha2, 8'ha2, 8'h00);
        cmp_word(i_mem.rd_first, BASE + 16'h0017);
        cmp_word(st(5), 16'h0001);
        cmp_word(st(1), 16'h0000);
        $display("test round robin done");
        // halt of a waiting program
        serve(8'h20, 8'h00, 8'h20);
        cmp_word({15'h0, i_mem.hp_seen[5]}, 16'h0001);
        cmp_word(st(5), 16'h0000);
        cmp_word({8'h0, halt_pending}, 16'h0000);
        $display("test halt done");
        // undefined opcode aborts
        entry(6, 16'h00b0);
        ins(16'hb0, 16'hfff0, 16'h0000);
        i_mem.mem[16'hc0] = 16'hffff;
        serve(8'h40, 8'h40, 8'h00);
        cmp_word(i_mem.mem[16'hc0], CPI_ABORT_BADOP);
        cmp_word(st(6), 16'h0000);
        cmp_word(16'(i_mem.bus_log.size()), 16'h0000);
        $display("test bad opcode done");
        // chained read counts its blocks down, then a relative jump
        entry(4, 16'h00d0);
        ins(16'hd0, 16'h0330, 16'h0020);
        ins(16'hd2, 16'h0000, 16'h0002);
        ins(16'hd4, 16'h0200, 16'h0000);
        ins(16'hd6, 16'h0200, 16'h0000);
        serve(8'h10, 8'h10, 8'h00);
        cmp_word(16'(i_mem.bus_log.size()), 16'h0003);
        cmp_word({4'h0, i_mem.bus_log[2]}, 16'h0c60);
        cmp_word(i_mem.mem[16'hd1], 16'h0000);
        cmp_word(i_mem.mem[BASE + 16], 16'h00d8);
        $display("test chain and jump done");
        finish_test();
    end
endmodule
`default_nettype wire
